// >>> hdl/irq_dispatch_pkg.sv
// Constants for the interrupt and exception dispatch unit.
// Assumes a 16-bit flag word and an 8-bit vector number.
package irq_dispatch_pkg;
    // ------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------
    localparam int unsigned VECTOR_COUNT = 256;
    localparam logic [7:0] VEC_DIVIDE = 8'h00;
    localparam logic [7:0] VEC_STEP = 8'h01;
    localparam logic [7:0] VEC_NMI = 8'h02;
    localparam logic [7:0] VEC_BREAK = 8'h03;
    localparam logic [7:0] VEC_OVERFLOW = 8'h04;
    localparam logic [7:0] VEC_RANGE = 8'h05;
    localparam logic [7:0] VEC_OPCODE = 8'h06;
    localparam logic [7:0] VEC_COPRO_NA = 8'h07;
    localparam logic [7:0] VEC_COPRO_ERR = 8'h10;
    localparam logic [7:0] VEC_OVERRUN = 8'h09;
    // ------------------------------------------------------------
    // Flag word layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned FLAG_STEP_BIT = 8;
    localparam int unsigned FLAG_IE_BIT = 9;
    localparam logic [15:0] FLAGS_RESET = 16'h0002;
    // Push order: flags, code segment, instruction pointer
    localparam logic [1:0] PUSH_FLAGS = 2'h0;
    localparam logic [1:0] PUSH_CS = 2'h1;
    localparam logic [1:0] PUSH_IP = 2'h2;
    localparam logic [1:0] PUSH_LAST = 2'h2;
    // Exception source codes on i_exc_code
    localparam logic [2:0] EXC_DIVIDE = 3'h0;
    localparam logic [2:0] EXC_BREAK = 3'h1;
    localparam logic [2:0] EXC_OVERFLOW = 3'h2;
    localparam logic [2:0] EXC_RANGE = 3'h3;
    localparam logic [2:0] EXC_OPCODE = 3'h4;
    localparam logic [2:0] EXC_COPRO_NA = 3'h5;
    localparam logic [2:0] EXC_COPRO_ERR = 3'h6;
endpackage

// >>> hdl/irq_return_stack.sv
// Small buffer holding the three pushed words of the last dispatch.
// Assumes the core writes one word per cycle; read data are registered.
`timescale 1ns/1ps
module irq_return_stack
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic [1:0] i_waddr,
    input wire logic [15:0] i_wdata,
    input wire logic [1:0] i_raddr,
    output logic [15:0] o_rdata
);
    logic [15:0] mem_q [0:3];
    logic [15:0] rdata_q;

    // Write port and registered read
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mem_q[0] <= 16'h0000;
            mem_q[1] <= 16'h0000;
            mem_q[2] <= 16'h0000;
            mem_q[3] <= 16'h0000;
            rdata_q <= 16'h0000;
        end
        else
        begin
            if (i_wr)
            begin
                mem_q[i_waddr] <= i_wdata;
            end
            rdata_q <= mem_q[i_raddr];
        end
    end

    assign o_rdata = rdata_q;
endmodule

// >>> hdl/interrupt_exception_dispatch.sv
// Interrupt and exception dispatch: vector choice, return-state push,
// enable and single-step flag handling, nested non-maskable blocking.
// Assumes the core pulses i_boundary between instructions and stalls
// fetch while o_busy is high; acknowledge vector arrives with i_ack_valid.
`timescale 1ns/1ps
module interrupt_exception_dispatch
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_boundary,
    input wire logic i_exc_req,
    input wire logic [2:0] i_exc_code,
    input wire logic [15:0] i_fault_ip,
    input wire logic [15:0] i_next_ip,
    input wire logic [15:0] i_cs,
    input wire logic i_swint_req,
    input wire logic [7:0] i_swint_vec,
    input wire logic i_nmi,
    input wire logic i_maskable_request_pin,
    input wire logic i_overrun_req,
    input wire logic i_ack_valid,
    input wire logic [7:0] i_ack_vector,
    input wire logic i_flags_wr,
    input wire logic [15:0] i_flags_wdata,
    input wire logic i_interrupt_return_instruction,
    input wire logic [15:0] i_ret_flags,
    output logic o_ack_cycle,
    output logic o_push,
    output logic [15:0] o_push_data,
    output logic o_dispatch,
    output logic [7:0] o_vector,
    output logic [9:0] o_table_addr,
    output logic [15:0] o_flags,
    output logic o_busy
);
    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [4:0]
    {
        ST_IDLE = 5'b00001,
        ST_ACK = 5'b00010,
        ST_PUSH = 5'b00100,
        ST_DONE = 5'b01000,
        ST_SPARE = 5'b10000
    } state_e;

    typedef struct packed
    {
        state_e state;
        logic [15:0] flags;
        logic [15:0] saved_flags;
        logic [15:0] ret_ip;
        logic [15:0] ret_cs;
        logic [7:0] vector;
        logic [1:0] push_idx;
        logic [1:0] push_slot;
        logic in_nmi;
        logic nmi_pend;
        logic nmi_prev;
        logic step_arm;
        logic is_nmi;
        logic push;
        logic [15:0] push_data;
        logic dispatch;
    } state_s;

    state_s cur_q;
    state_s nxt_d;

    // Exception code to fixed vector
    function automatic logic [7:0] exc_vector(input logic [2:0] code);
        logic [7:0] v;
        v = irq_dispatch_pkg::VEC_OPCODE;
        case (code)
            irq_dispatch_pkg::EXC_DIVIDE: v = irq_dispatch_pkg::VEC_DIVIDE;
            irq_dispatch_pkg::EXC_BREAK: v = irq_dispatch_pkg::VEC_BREAK;
            irq_dispatch_pkg::EXC_OVERFLOW: v = irq_dispatch_pkg::VEC_OVERFLOW;
            irq_dispatch_pkg::EXC_RANGE: v = irq_dispatch_pkg::VEC_RANGE;
            irq_dispatch_pkg::EXC_OPCODE: v = irq_dispatch_pkg::VEC_OPCODE;
            irq_dispatch_pkg::EXC_COPRO_NA: v = irq_dispatch_pkg::VEC_COPRO_NA;
            irq_dispatch_pkg::EXC_COPRO_ERR: v = irq_dispatch_pkg::VEC_COPRO_ERR;
            default: v = irq_dispatch_pkg::VEC_OPCODE;
        endcase
        return v;
    endfunction

    logic nmi_edge;
    logic ie;
    logic [15:0] stack_rdata;

    assign nmi_edge = i_nmi & ~cur_q.nmi_prev;
    assign ie = cur_q.flags[irq_dispatch_pkg::FLAG_IE_BIT];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_d = cur_q;
        nxt_d.push = 1'b0;
        nxt_d.dispatch = 1'b0;
        nxt_d.nmi_prev = i_nmi;
        // Edge stored even mid-dispatch so a nested request is kept
        if (nmi_edge)
        begin
            nxt_d.nmi_pend = 1'b1;
        end
        if (i_flags_wr && cur_q.state == ST_IDLE)
        begin
            nxt_d.flags = i_flags_wdata;
        end
        // Return restores whole flag word and ends the nmi window
        if (i_interrupt_return_instruction && cur_q.state == ST_IDLE)
        begin
            nxt_d.flags = i_ret_flags;
            nxt_d.in_nmi = 1'b0;
        end
        case (cur_q.state)
            ST_IDLE:
            begin
                // Step arms on the boundary after the flag is seen set
                if (i_boundary)
                begin
                    nxt_d.step_arm = cur_q.flags[irq_dispatch_pkg::FLAG_STEP_BIT];
                end
                if (i_boundary)
                begin
                    nxt_d.saved_flags = cur_q.flags;
                    nxt_d.ret_cs = i_cs;
                    nxt_d.is_nmi = 1'b0;
                    nxt_d.push_idx = irq_dispatch_pkg::PUSH_FLAGS;
                    // Fixed priority chain
                    if (i_exc_req)
                    begin
                        nxt_d.vector = exc_vector(i_exc_code);
                        // Overflow trap resumes past, faults retry
                        nxt_d.ret_ip = (i_exc_code == irq_dispatch_pkg::EXC_OVERFLOW) ?
                            i_next_ip : i_fault_ip;
                        nxt_d.state = ST_PUSH;
                    end
                    else if (cur_q.step_arm)
                    begin
                        nxt_d.vector = irq_dispatch_pkg::VEC_STEP;
                        nxt_d.ret_ip = i_next_ip;
                        nxt_d.step_arm = 1'b0;
                        nxt_d.state = ST_PUSH;
                    end
                    else if ((cur_q.nmi_pend || nmi_edge) && !cur_q.in_nmi)
                    begin
                        nxt_d.vector = irq_dispatch_pkg::VEC_NMI;
                        nxt_d.ret_ip = i_next_ip;
                        nxt_d.nmi_pend = 1'b0;
                        nxt_d.is_nmi = 1'b1;
                        nxt_d.state = ST_PUSH;
                    end
                    else if (i_overrun_req && !cur_q.in_nmi)
                    begin
                        nxt_d.vector = irq_dispatch_pkg::VEC_OVERRUN;
                        nxt_d.ret_ip = i_next_ip;
                        nxt_d.state = ST_PUSH;
                    end
                    else if (i_maskable_request_pin && ie && !cur_q.in_nmi)
                    begin
                        nxt_d.ret_ip = i_next_ip;
                        nxt_d.state = ST_ACK;
                    end
                    else if (i_swint_req)
                    begin
                        nxt_d.vector = i_swint_vec;
                        nxt_d.ret_ip = i_next_ip;
                        nxt_d.state = ST_PUSH;
                    end
                end
            end
            ST_ACK:
            begin
                // Wait for the controller's vector
                if (i_ack_valid)
                begin
                    nxt_d.vector = i_ack_vector;
                    nxt_d.state = ST_PUSH;
                end
            end
            ST_PUSH:
            begin
                // Flags, then CS, then IP
                nxt_d.push = 1'b1;
                nxt_d.push_slot = cur_q.push_idx; // Slot travels with its word
                case (cur_q.push_idx)
                    irq_dispatch_pkg::PUSH_FLAGS: nxt_d.push_data = cur_q.saved_flags;
                    irq_dispatch_pkg::PUSH_CS: nxt_d.push_data = cur_q.ret_cs;
                    default: nxt_d.push_data = cur_q.ret_ip;
                endcase
                if (cur_q.push_idx == irq_dispatch_pkg::PUSH_LAST)
                begin
                    nxt_d.state = ST_DONE;
                end
                else
                begin
                    nxt_d.push_idx = cur_q.push_idx + 2'h1;
                end
            end
            ST_DONE:
            begin
                // Clear enable and step only after the old flags went out
                nxt_d.flags[irq_dispatch_pkg::FLAG_IE_BIT] = 1'b0;
                nxt_d.flags[irq_dispatch_pkg::FLAG_STEP_BIT] = 1'b0;
                if (cur_q.is_nmi)
                begin
                    nxt_d.in_nmi = 1'b1;
                end
                nxt_d.dispatch = 1'b1;
                nxt_d.state = ST_IDLE;
            end
            default:
            begin
                nxt_d.state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cur_q <= '{state: ST_IDLE, flags: irq_dispatch_pkg::FLAGS_RESET,
                       default: '0};
        end
        else
        begin
            cur_q <= nxt_d;
        end
    end

    // Copy of pushed words, kept for debug readback of slot 0
    irq_return_stack u_stack
    (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_wr(cur_q.push),
        .i_waddr(cur_q.push_slot),
        .i_wdata(cur_q.push_data),
        .i_raddr(irq_dispatch_pkg::PUSH_FLAGS),
        .o_rdata(stack_rdata)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_ack_cycle = (cur_q.state == ST_ACK);
    assign o_push = cur_q.push;
    assign o_push_data = cur_q.push_data;
    assign o_dispatch = cur_q.dispatch;
    assign o_vector = cur_q.vector;
    // Four bytes per table entry
    assign o_table_addr = {cur_q.vector, 2'b00};
    assign o_flags = cur_q.flags;
    // Fetch held off while dispatching
    assign o_busy = (cur_q.state != ST_IDLE) || cur_q.dispatch;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_nmi_no_ack: assert property (@(posedge i_mclk) disable iff (i_rst)
        (cur_q.state == ST_IDLE && i_boundary && !i_exc_req && !cur_q.step_arm &&
         cur_q.nmi_pend && !cur_q.in_nmi) |=> (!o_ack_cycle && o_vector == 8'h02))
        else $error("nmi dispatch used acknowledge or wrong vector");
    a_mask_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
        (cur_q.state == ST_IDLE && !ie) |=> !o_ack_cycle)
        else $error("acknowledge started with enable clear");
    a_ie_cleared: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_dispatch |-> !o_flags[9])
        else $error("enable still set after dispatch");
    a_step_cleared: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_dispatch |-> !o_flags[8])
        else $error("single step flag not cleared by dispatch");
    a_three_pushes: assert property (@(posedge i_mclk) disable iff (i_rst)
        (o_push && !$past(o_push)) |-> o_push [*3] ##1 (!o_push && o_dispatch))
        else $error("push sequence not three words then dispatch");
    a_nmi_blocks: assert property (@(posedge i_mclk) disable iff (i_rst)
        cur_q.in_nmi |-> !o_ack_cycle)
        else $error("maskable acknowledged inside nmi handler");
    a_step_vector: assert property (@(posedge i_mclk) disable iff (i_rst)
        (cur_q.state == ST_IDLE && i_boundary && !i_exc_req && cur_q.step_arm)
        |=> o_vector == 8'h01)
        else $error("single step lost priority");
    a_interrupt_return_instruction_flags: assert property (@(posedge i_mclk) disable iff (i_rst)
        (cur_q.state == ST_IDLE && i_interrupt_return_instruction)
        |=> o_flags == $past(i_ret_flags))
        else $error("return did not restore flags");
    a_fault_ip: assert property (@(posedge i_mclk) disable iff (i_rst)
        (cur_q.state == ST_IDLE && i_boundary && i_exc_req && i_exc_code != 3'h2)
        |=> cur_q.ret_ip == $past(i_fault_ip))
        else $error("fault return address wrong");
    a_dispatch_soon: assert property (@(posedge i_mclk) disable iff (i_rst)
        (cur_q.state == ST_IDLE && i_boundary && i_exc_req) |-> ##[1:6] o_dispatch)
        else $error("exception not dispatched in time");
    a_stack_flags: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_dispatch |-> stack_rdata == cur_q.saved_flags)
        else $error("mirrored flag word differs from saved flags");

    c_nmi: cover property (@(posedge i_mclk) disable iff (i_rst)
        o_dispatch && o_vector == 8'h02);
    c_ack: cover property (@(posedge i_mclk) disable iff (i_rst)
        o_ack_cycle ##1 !o_ack_cycle);
    c_nested: cover property (@(posedge i_mclk) disable iff (i_rst)
        cur_q.in_nmi && cur_q.nmi_pend);
    c_step: cover property (@(posedge i_mclk) disable iff (i_rst)
        o_dispatch && o_vector == 8'h01);
endmodule

// >>> sim/irq_controller_model.sv
// External interrupt controller that answers the acknowledge sequence.
// Assumes the bench arms one request at a time; changes follow rising edges.
`timescale 1ns/1ps
module irq_controller_model
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_arm,
    input wire logic [7:0] i_vec,
    input wire logic [3:0] i_delay,
    input wire logic i_ack_cycle,
    output logic o_request,
    output logic o_ack_valid,
    output logic [7:0] o_ack_vector
);
    // ------------------------------------------------------------
    // Request, wait and vector answer
    // ------------------------------------------------------------
    logic [7:0] vec_q;
    logic [3:0] wait_q;

    // Vector lines toggle when not answering, so a stale value never matches
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_request <= 1'b0;
            o_ack_valid <= 1'b0;
            o_ack_vector <= 8'h00;
            vec_q <= 8'h00;
            wait_q <= 4'h0;
        end
        else
        begin
            o_ack_valid <= 1'b0;
            if (i_arm)
            begin
                o_request <= 1'b1;
                vec_q <= i_vec;
            end
            if (o_ack_valid)
            begin
                o_request <= 1'b0;
                o_ack_vector <= ~o_ack_vector;
            end
            else if (i_ack_cycle && o_request)
            begin
                if (wait_q == i_delay)
                begin
                    o_ack_valid <= 1'b1;
                    o_ack_vector <= vec_q;
                    wait_q <= 4'h0;
                end
                else
                begin
                    wait_q <= wait_q + 4'h1;
                    o_ack_vector <= ~o_ack_vector;
                end
            end
            else
                o_ack_vector <= ~o_ack_vector;
        end
    end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the interrupt and exception dispatch unit.
// Assumes inputs change at falling edges and the design samples on rising.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic i_mclk = 1'b0, i_rst = 1'b1, i_boundary = 1'b0, i_exc_req = 1'b0;
    logic [2:0] i_exc_code = 3'h0;
    logic [15:0] i_fault_ip = 16'h0000, i_next_ip = 16'h0000, i_cs = 16'h0000;
    logic i_swint_req = 1'b0, i_nmi = 1'b0, i_overrun_req = 1'b0;
    logic [7:0] i_swint_vec = 8'h00, i_ack_vector, arm_vec = 8'h00;
    logic i_maskable_request_pin, i_ack_valid, arm = 1'b0;
    logic i_flags_wr = 1'b0, i_interrupt_return_instruction = 1'b0;
    logic [15:0] i_flags_wdata = 16'h0000, i_ret_flags = 16'h0000;
    logic o_ack_cycle, o_push, o_dispatch, o_busy;
    logic [15:0] o_push_data, o_flags;
    logic [7:0] o_vector;
    logic [9:0] o_table_addr;
    int error_cnt = 0, compares = 0, cycles = 0;
    logic [7:0] exc_vec [7] = '{irq_dispatch_pkg::VEC_DIVIDE, irq_dispatch_pkg::VEC_BREAK,
        irq_dispatch_pkg::VEC_OVERFLOW, irq_dispatch_pkg::VEC_RANGE,
        irq_dispatch_pkg::VEC_OPCODE, irq_dispatch_pkg::VEC_COPRO_NA,
        irq_dispatch_pkg::VEC_COPRO_ERR};

    interrupt_exception_dispatch interrupt_exception_dispatch_i (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_boundary(i_boundary), .i_exc_req(i_exc_req),
        .i_exc_code(i_exc_code), .i_fault_ip(i_fault_ip), .i_next_ip(i_next_ip),
        .i_cs(i_cs), .i_swint_req(i_swint_req), .i_swint_vec(i_swint_vec), .i_nmi(i_nmi),
        .i_maskable_request_pin(i_maskable_request_pin), .i_overrun_req(i_overrun_req),
        .i_ack_valid(i_ack_valid), .i_ack_vector(i_ack_vector), .i_flags_wr(i_flags_wr),
        .i_flags_wdata(i_flags_wdata),
        .i_interrupt_return_instruction(i_interrupt_return_instruction),
        .i_ret_flags(i_ret_flags), .o_ack_cycle(o_ack_cycle), .o_push(o_push),
        .o_push_data(o_push_data), .o_dispatch(o_dispatch), .o_vector(o_vector),
        .o_table_addr(o_table_addr), .o_flags(o_flags), .o_busy(o_busy));

    irq_controller_model irq_controller_model_i (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_arm(arm), .i_vec(arm_vec), .i_delay(4'h2), .i_ack_cycle(o_ack_cycle),
        .o_request(i_maskable_request_pin), .o_ack_valid(i_ack_valid),
        .o_ack_vector(i_ack_vector));

    // ------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------
    always #50 i_mclk = ~i_mclk;

    // Ceiling far above the roughly 150 cycles the scenarios need
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Shared drivers and the dispatch observer
    // ------------------------------------------------------------
    // One boundary pulse carrying the given exception and software requests
    task automatic take(input logic exc, input logic [2:0] code, input logic sw,
        input logic [7:0] swv);
        i_boundary = 1'b1;
        i_exc_req = exc;
        i_exc_code = code;
        i_swint_req = sw;
        i_swint_vec = swv;
        @(negedge i_mclk);
        i_boundary = 1'b0;
        i_exc_req = 1'b0;
        i_swint_req = 1'b0;
    endtask

    task automatic set_flags(input logic [15:0] v, input logic is_ret);
        i_flags_wr = ~is_ret;
        i_interrupt_return_instruction = is_ret;
        i_flags_wdata = v;
        i_ret_flags = v;
        @(negedge i_mclk);
        i_flags_wr = 1'b0;
        i_interrupt_return_instruction = 1'b0;
        `CHK(o_flags, v)
    endtask

    // Four boundaries (or quiet cycles) at which nothing may be taken
    task automatic no_take(input logic bnd);
        for (int n = 0; n < 5; n++)
        begin
            @(negedge i_mclk);
            `CHK(o_busy, 1'b0)
            i_boundary = bnd && (n < 4);
        end
        @(negedge i_mclk);
    endtask

    // Collects pushed words until the dispatch pulse, then checks all of it
    task automatic dispatch_chk(input logic [7:0] v, input logic [15:0] fl,
        input logic [15:0] ip, input logic ack_exp);
        logic [15:0] w [3];
        int np;
        logic ack_seen;
        np = 0;
        ack_seen = 1'b0;
        for (int n = 0; n < 60 && o_dispatch !== 1'b1; n++)
        begin
            @(negedge i_mclk);
            if (o_push === 1'b1 && np < 3)
            begin
                w[np] = o_push_data;
                np++;
            end
            if (o_ack_cycle === 1'b1)
                ack_seen = 1'b1;
        end
        `CHK(o_dispatch, 1'b1)
        `CHK(o_vector, v)
        `CHK(o_table_addr, {v, 2'b00})
        `CHK(np, 3)
        `CHK(w[0], fl)
        `CHK(w[1], i_cs)
        `CHK(w[2], ip)
        `CHK(ack_seen, ack_exp)
        `CHK(o_flags, fl & 16'hfcff)
        @(negedge i_mclk);
        `CHK(o_dispatch, 1'b0)
        `CHK(o_busy, 1'b0)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every exception code, each racing a software interrupt it must beat
    task automatic exc_scan();
        for (int k = 0; k < 7; k++)
        begin
            i_cs = 16'h1000 + 16'(k);
            i_fault_ip = 16'h0100 + 16'(k);
            i_next_ip = 16'h0200 + 16'(k);
            set_flags(16'h0202, 1'b0);
            take(1'b1, 3'(k), 1'b1, 8'h20);
            dispatch_chk(exc_vec[k], 16'h0202, (k == 2) ? i_next_ip : i_fault_ip,
                1'b0);
        end
    endtask

    // Top software vector reaches the last table entry
    task automatic soft_int();
        set_flags(16'h0202, 1'b0);
        take(1'b0, 3'h0, 1'b1, 8'hff);
        dispatch_chk(8'hff, 16'h0202, i_next_ip, 1'b0);
    endtask

    // Step arms at one boundary and fires at the following one
    task automatic single_step();
        set_flags(16'h0102, 1'b0);
        take(1'b0, 3'h0, 1'b0, 8'h00);
        no_take(1'b0);
        take(1'b0, 3'h0, 1'b0, 8'h00);
        dispatch_chk(irq_dispatch_pkg::VEC_STEP, 16'h0102, i_next_ip, 1'b0);
        set_flags(16'h0102, 1'b1);
        // Restored step flag must step the following instruction again
        take(1'b0, 3'h0, 1'b0, 8'h00);
        no_take(1'b0);
        take(1'b0, 3'h0, 1'b0, 8'h00);
        dispatch_chk(irq_dispatch_pkg::VEC_STEP, 16'h0102, i_next_ip, 1'b0);
        set_flags(16'h0002, 1'b0);
    endtask

    // Masking, priority, nested blocking and the latched second request
    task automatic nmi_nesting();
        set_flags(16'h0002, 1'b0);
        arm_vec = 8'h40;
        arm = 1'b1;
        take(1'b0, 3'h0, 1'b0, 8'h00);
        arm = 1'b0;
        no_take(1'b1);
        set_flags(16'h0202, 1'b0);
        i_nmi = 1'b1;
        take(1'b0, 3'h0, 1'b0, 8'h00);
        dispatch_chk(irq_dispatch_pkg::VEC_NMI, 16'h0202, i_next_ip, 1'b0);
        set_flags(16'h0202, 1'b0);
        i_nmi = 1'b0;
        @(negedge i_mclk);
        i_nmi = 1'b1;
        i_overrun_req = 1'b1;
        take(1'b0, 3'h0, 1'b0, 8'h00);
        no_take(1'b1);
        i_overrun_req = 1'b0;
        set_flags(16'h0202, 1'b1);
        take(1'b0, 3'h0, 1'b0, 8'h00);
        dispatch_chk(irq_dispatch_pkg::VEC_NMI, 16'h0202, i_next_ip, 1'b0);
        i_nmi = 1'b0;
        set_flags(16'h0202, 1'b1);
        i_overrun_req = 1'b1;
        take(1'b0, 3'h0, 1'b0, 8'h00);
        dispatch_chk(irq_dispatch_pkg::VEC_OVERRUN, 16'h0202, i_next_ip, 1'b0);
        i_overrun_req = 1'b0;
        set_flags(16'h0202, 1'b1);
        take(1'b0, 3'h0, 1'b0, 8'h00);
        dispatch_chk(8'h40, 16'h0202, i_next_ip, 1'b1);
    endtask

    // Reset inside a non-maskable handler reopens the window
    task automatic reset_nmi();
        i_nmi = 1'b1;
        take(1'b0, 3'h0, 1'b0, 8'h00);
        dispatch_chk(irq_dispatch_pkg::VEC_NMI, 16'h0002, i_next_ip, 1'b0);
        i_nmi = 1'b0;
        i_rst = 1'b1;
        @(negedge i_mclk);
        i_rst = 1'b0;
        `CHK(o_flags, irq_dispatch_pkg::FLAGS_RESET)
        `CHK(o_busy, 1'b0)
        i_nmi = 1'b1;
        take(1'b0, 3'h0, 1'b0, 8'h00);
        dispatch_chk(irq_dispatch_pkg::VEC_NMI, 16'h0002, i_next_ip, 1'b0);
        i_nmi = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(negedge i_mclk);
        i_rst = 1'b0;
        `CHK(o_flags, irq_dispatch_pkg::FLAGS_RESET)
        `CHK(o_busy, 1'b0)
        `CHK(o_push, 1'b0)
        exc_scan();
        soft_int();
        single_step();
        nmi_nesting();
        reset_nmi();
        tally_and_finish();
    end
endmodule
